// ### core/ssc_status_regs.sv
// Serial status register bank and peak current selection of the stepper driver
// Contract
// [R1] Five-bit code selects coil peak current
// [R2] Four code ranges; lowering across may flag
// [R3] Four read-only status bytes, zero after reset
// [R4] Live byte: check, thermal, pump, watchdog, opens
// [R5] X bridge byte: check, four latched overcurrents
// [R6] Y bridge byte: overcurrents plus thermal shutdown
// [R7] Step byte: live check bit, step position
// [R8] Pump fault flag follows charge pump failure
// [R9] Coil break flags report open coils
// [R10] Overcurrent flags report per-transistor overcurrent
// [R11] Watchdog flag set after watchdog reset
// [R12] Master reads watchdog flag to tell boots
// [R13] Only writing enable zero clears watchdog flag
// [R14] Output buffer loads on eighth falling edge
// [R15] Latched flags hold until register read
module ssc_status_regs
  import ssc_pkg::*;
(
  input  wire logic       clk,                    // System clock, 125 MHz
  input  wire logic       sys_rst,                // Asynchronous reset, active high
  input  wire logic       spiClk,                 // Serial clock pin, idle low
  input  wire logic       spiCs_n,                // Chip select pin
  input  wire logic       spiDataIn,              // Serial data pin from master
  output logic            spiDataOut,             // Serial data to master
  output logic            spiDataOutEn_n,         // Low while data pin is driven
  input  wire logic       thermalWarningIn,       // Analog thermal warning
  input  wire logic       pumpFaultIn,            // Charge pump below level
  input  wire logic       coilXBreakIn,           // Open coil X detected
  input  wire logic       coilYBreakIn,           // Open coil Y detected
  input  wire logic       watchdogTimeoutIn,      // Watchdog reset after time-out
  input  wire logic [3:0] xOvercurrentIn,         // X pos top, pos bot, neg top, neg bot
  input  wire logic [3:0] yOvercurrentIn,         // Y pos top, pos bot, neg top, neg bot
  input  wire logic       thermalShutdownIn,      // Analog thermal shutdown
  input  wire logic [6:0] translatorStepPosition, // From translator, same clock
  output logic [4:0]      peakAmpCode,            // Selected coil peak level code
  output logic [1:0]      peakRange,              // Range index of the code
  output logic            rangeLowered,           // Pulse: code moved to lower range
  output logic            watchdogEnableBit       // Stored watchdog enable
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SYNC_WIDTH-1:0] syncIn;     // Raw asynchronous pins
  logic [SYNC_WIDTH-1:0] sync1_reg;  // First stage, read only by second
  logic [SYNC_WIDTH-1:0] sync2_reg;  // Second stage, safe to use
  logic                  sclkPrev_reg;  // Delayed serial clock for edges

  assign syncIn = {spiClk, spiCs_n, spiDataIn, thermalWarningIn, pumpFaultIn,
                   coilXBreakIn, coilYBreakIn, watchdogTimeoutIn, xOvercurrentIn,
                   yOvercurrentIn, thermalShutdownIn};

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      sclkPrev_reg <= 1'b0;
    end else begin
      sync1_reg    <= syncIn;
      sync2_reg    <= sync1_reg;
      sclkPrev_reg <= sync2_reg[16];
    end
  end

  // Named views of the synchronised pins
  wire       sclkS    = sync2_reg[16];
  wire       csS_n    = sync2_reg[15];
  wire       dinS     = sync2_reg[14];
  wire       thermS   = sync2_reg[13];
  wire       pumpS    = sync2_reg[12];
  wire       xOpenS   = sync2_reg[11];
  wire       yOpenS   = sync2_reg[10];
  wire       wdogS    = sync2_reg[9];
  wire [3:0] xOvcS    = sync2_reg[8:5];
  wire [3:0] yOvcS    = sync2_reg[4:1];
  wire       tsdS     = sync2_reg[0];
  wire       sclkRise = ~csS_n & sclkS & ~sclkPrev_reg;
  wire       sclkFall = ~csS_n & ~sclkS & sclkPrev_reg;

  // ****************************************************************
  // Serial framing state
  // ****************************************************************
  logic [2:0] bitCnt_reg;    // Bits received in current byte
  logic [6:0] shiftIn_reg;   // Bits received so far
  logic [7:0] cmd_reg;       // Command byte of the frame
  logic       dataByte_reg;  // Next completed byte is a data byte
  logic       loadPend_reg;  // A byte ended; next fall loads buffer
  logic [7:0] shiftOut_reg;  // Output shift buffer

  wire [7:0] rxByte   = {shiftIn_reg, dinS};
  wire       byteDone = sclkRise & (bitCnt_reg == LAST_BIT);
  wire       cmdDone  = byteDone & ~dataByte_reg;
  wire       dataDone = byteDone & dataByte_reg & cmd_reg[CMD_WRITE_BIT];
  // Address used for the buffer load: the fresh command once it is stored
  wire [4:0] selAddr  = cmd_reg[CMD_ADDR_MSB:0];
  wire       bufLoad  = sclkFall & loadPend_reg;  // [R14]
  wire       readLoad = bufLoad & ~cmd_reg[CMD_WRITE_BIT];

  // Receive side samples on rising serial clock; chip select high restarts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCnt_reg   <= 3'h0;
      shiftIn_reg  <= 7'h00;
      cmd_reg      <= 8'h00;
      dataByte_reg <= 1'b0;
      loadPend_reg <= 1'b0;
    end else if (csS_n) begin
      bitCnt_reg   <= 3'h0;
      dataByte_reg <= 1'b0;
      loadPend_reg <= 1'b0;
    end else begin
      if (sclkRise) begin
        bitCnt_reg  <= bitCnt_reg + 3'h1;
        shiftIn_reg <= rxByte[6:0];
      end
      if (cmdDone) begin
        cmd_reg <= rxByte;
      end
      if (byteDone) begin
        dataByte_reg <= ~dataByte_reg;
      end
      // Load waits for the eighth falling edge, so the first byte is stale
      if (byteDone) begin
        loadPend_reg <= 1'b1;  // [R14]
      end else if (bufLoad) begin
        loadPend_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control registers written by the master
  // ****************************************************************
  wire wrWdog = dataDone & (selAddr == ADDR_WDOG_CTRL);
  wire wrPeak = dataDone & (selAddr == ADDR_PEAK_CTRL);
  wire wdClr  = wrWdog & ~rxByte[WDOG_EN_POS];  // [R13]
  wire [1:0] newRange = rxByte[PEAK_CODE_MSB:PEAK_RANGE_LSB];

  // Code is stored as is; the analog DAC maps it monotonically
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      peakAmpCode       <= PEAK_CODE_RST;
      peakRange         <= 2'h0;
      rangeLowered      <= 1'b0;
      watchdogEnableBit <= 1'b0;
    end else begin
      rangeLowered <= wrPeak & (newRange < peakRange);  // [R2]
      if (wrPeak) begin
        peakAmpCode <= rxByte[PEAK_CODE_MSB:0];  // [R1]
        peakRange   <= newRange;                 // [R2]
      end
      if (wrWdog) begin
        watchdogEnableBit <= rxByte[WDOG_EN_POS];
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic [3:0] xLatch_reg;   // Latched X overcurrents
  logic [3:0] yLatch_reg;   // Latched Y overcurrents
  logic       tsdLatch_reg; // Latched thermal shutdown
  logic       wdFlag_reg;   // Watchdog event, held until a clear or sys_rst

  wire clrX = readLoad & (selAddr == ADDR_X_BRIDGE);  // [R15]
  wire clrY = readLoad & (selAddr == ADDR_Y_BRIDGE);  // [R15]

  // A new event in the clearing cycle wins, so no fault slips past a read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xLatch_reg   <= 4'h0;  // [R3]
      yLatch_reg   <= 4'h0;
      tsdLatch_reg <= 1'b0;
      wdFlag_reg   <= 1'b0;
    end else begin
      xLatch_reg   <= (xLatch_reg & ~{4{clrX}}) | xOvcS;  // [R10] [R15]
      yLatch_reg   <= (yLatch_reg & ~{4{clrY}}) | yOvcS;  // [R10] [R15]
      tsdLatch_reg <= (tsdLatch_reg & ~clrY) | tsdS;      // [R6] [R15]
      wdFlag_reg   <= (wdFlag_reg & ~wdClr) | wdogS;      // [R11] [R13]
    end
  end

  // ****************************************************************
  // Status words and read selection
  // ****************************************************************
  logic [6:0] liveLow;  // Live byte below the check bit
  logic [6:0] xLow;
  logic [6:0] yLow;
  logic [6:0] stepLow;
  logic [7:0] selData;  // Word chosen for the next buffer load

  assign liveLow = {thermS, pumpS, wdFlag_reg, xOpenS, yOpenS, 2'b00};  // [R4] [R8] [R9]
  assign xLow    = {xLatch_reg, 3'b000};                                 // [R5]
  assign yLow    = {yLatch_reg, tsdLatch_reg, 2'b00};                    // [R6]
  assign stepLow = translatorStepPosition;                               // [R7]

  // Check bit makes each word even parity; unmapped reads give zero
  always_comb begin
    unique case (selAddr)
      ADDR_LIVE_DIAG: selData = {^liveLow, liveLow};  // [R4]
      ADDR_X_BRIDGE:  selData = {^xLow, xLow};        // [R5]
      ADDR_Y_BRIDGE:  selData = {^yLow, yLow};        // [R6]
      ADDR_STEP_POS:  selData = {^stepLow, stepLow};  // [R7]
      default:        selData = STATUS_RST;
    endcase
  end

  // ****************************************************************
  // Transmit side: shift on falling edges, load on the eighth
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftOut_reg   <= STATUS_RST;  // [R3]
      spiDataOut     <= 1'b0;
      spiDataOutEn_n <= 1'b1;
    end else begin
      spiDataOut     <= shiftOut_reg[CHECK_BIT_POS];
      spiDataOutEn_n <= csS_n;
      if (bufLoad) begin
        shiftOut_reg <= selData;  // [R14]
      end else if (sclkFall) begin
        shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_pump_held;
    pumpFaultIn [*3];
  endsequence
  sequence s_wdog_held;
    watchdogTimeoutIn [*4];
  endsequence

  property p_peak_write;
    wrPeak |=> peakAmpCode == $past(rxByte[4:0]);
  endproperty
  a_peak_write: assert property (p_peak_write) else $error("peak code not stored"); // [R1]

  property p_range_drop;
    (wrPeak && newRange < peakRange) |=> rangeLowered ##1 !rangeLowered;
  endproperty
  a_range_drop: assert property (p_range_drop) else $error("range drop not flagged"); // [R2]

  property p_reset_zero;
    $fell(sys_rst) |-> xLatch_reg == 4'h0 && yLatch_reg == 4'h0 && !wdFlag_reg;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset"); // [R3]

  property p_live_check;
    bufLoad && selAddr == ADDR_LIVE_DIAG |=> ^shiftOut_reg == 1'b0;
  endproperty
  a_live_check: assert property (p_live_check) else $error("live word parity wrong"); // [R4]

  property p_pump;
    s_pump_held |-> liveLow[LIVE_PUMP_POS];
  endproperty
  a_pump: assert property (p_pump) else $error("pump fault not reported"); // [R8]

  property p_open_x;
    coilXBreakIn [*3] |-> liveLow[LIVE_XOPEN_POS];
  endproperty
  a_open_x: assert property (p_open_x) else $error("open coil not reported"); // [R9]

  property p_ovc_set;
    xOvcS[3] |=> xLatch_reg[3] && (selAddr != ADDR_X_BRIDGE || selData[6]);
  endproperty
  a_ovc_set: assert property (p_ovc_set) else $error("overcurrent not latched"); // [R10]

  property p_wdog_set;
    s_wdog_held |-> wdFlag_reg;
  endproperty
  a_wdog_set: assert property (p_wdog_set) else $error("watchdog flag not set"); // [R11]

  property p_wdog_hold;
    wdFlag_reg && !wdClr |=> wdFlag_reg;
  endproperty
  a_wdog_hold: assert property (p_wdog_hold) else $error("watchdog flag lost"); // [R13]

  property p_load_edge;
    bufLoad |=> shiftOut_reg == $past(selData) ##0 !loadPend_reg;
  endproperty
  a_load_edge: assert property (p_load_edge) else $error("buffer load wrong"); // [R14]

  property p_latch_hold;
    xLatch_reg[0] && !clrX |=> xLatch_reg[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped"); // [R15]

endmodule // ssc_status_regs

// ### core/ssc_pkg.sv
// Constants shared by the stepper status and current register bank
package ssc_pkg;

  // ****************************************************************
  // Register addresses (five-bit serial address field)
  // ****************************************************************
  localparam logic [4:0] ADDR_WDOG_CTRL = 5'h00;  // Holds watchdog_enable_bit
  localparam logic [4:0] ADDR_PEAK_CTRL = 5'h01;  // Holds peak_amp_code
  localparam logic [4:0] ADDR_LIVE_DIAG = 5'h04;  // live_diag_status
  localparam logic [4:0] ADDR_X_BRIDGE  = 5'h05;  // x_bridge_fault_status
  localparam logic [4:0] ADDR_Y_BRIDGE  = 5'h06;  // y_bridge_thermal_status
  localparam logic [4:0] ADDR_STEP_POS  = 5'h07;  // step_position_status

  // ****************************************************************
  // Command byte layout
  // ****************************************************************
  localparam int CMD_WRITE_BIT = 7;  // One = write, zero = read
  localparam int CMD_ADDR_MSB  = 4;  // Address in bits 4..0

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CHECK_BIT_POS  = 7;  // check_bit_top in every status word
  localparam int WDOG_EN_POS    = 7;  // watchdog_enable_bit in control word
  localparam int PEAK_CODE_MSB  = 4;  // peak_amp_code in bits 4..0
  localparam int PEAK_RANGE_LSB = 3;  // Range index is the top two code bits
  localparam int LIVE_THERM_POS = 6;
  localparam int LIVE_PUMP_POS  = 5;
  localparam int LIVE_WDOG_POS  = 4;
  localparam int LIVE_XOPEN_POS = 3;
  localparam int LIVE_YOPEN_POS = 2;

  // ****************************************************************
  // Reset values and framing
  // ****************************************************************
  localparam logic [7:0] STATUS_RST    = 8'h00;
  localparam logic [4:0] PEAK_CODE_RST = 5'h00;
  localparam logic [2:0] LAST_BIT      = 3'h7;  // Eighth bit of a byte
  localparam int         SYNC_WIDTH    = 17;    // Pins passed through synchronisers

endpackage : ssc_pkg

// ### verification/ssc_spi_master.sv
// Serial master model that stands in for the external microcontroller
module ssc_spi_master (
  input  wire logic clk,            // System clock, paces the serial timing
  output logic      spiClk,         // Serial clock, idle low, still outside frames
  output logic      spiCs_n,        // Chip select, active low
  output logic      spiDataIn,      // Data towards the device
  input  wire logic spiDataOut,     // Data from the device
  input  wire logic spiDataOutEn_n  // Low while the device drives its pin
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 8;  // System clocks per serial phase, three above the minimum of five
  logic lastBit;            // Last level seen on the data pin
  logic pinLevel;           // Wire level as this model sees it
  // No pull on the pin: a released pin shows the inverse of its last level
  assign pinLevel = spiDataOutEn_n ? ~lastBit : spiDataOut;
  initial begin
    spiClk    = 1'b0;
    spiCs_n   = 1'b1;
    spiDataIn = 1'b0;
    lastBit   = 1'b0;
  end
  // ****************************************************************
  // One framed transfer: command byte then data byte, MSB first
  // ****************************************************************
  task automatic xfer(input logic [7:0] cmdByte, input logic [7:0] dataByte,
                      output logic [7:0] firstByte, output logic [7:0] secondByte);
    logic [15:0] outWord;
    logic [15:0] inWord;
    outWord = {cmdByte, dataByte};
    @(posedge clk);
    spiCs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      spiDataIn <= outWord[i];  // Data changes while the clock is low
      repeat (HALF) @(posedge clk);
      spiClk    <= 1'b1;
      inWord[i] = pinLevel;     // Mode 0: sampled at the rising edge
      lastBit   = pinLevel;
      repeat (HALF) @(posedge clk);
      spiClk    <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    spiCs_n   <= 1'b1;
    spiDataIn <= ~spiDataIn;    // Line no longer meaningful outside a frame
    repeat (HALF) @(posedge clk);
    firstByte  = inWord[15:8];  // May hold stale buffer contents
    secondByte = inWord[7:0];
  endtask
endmodule // ssc_spi_master

// ### verification/tb_ssc_status_regs.sv
// Self-checking testbench of the stepper status and current register bank
module tb_ssc_status_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import ssc_pkg::*;
  localparam int LIMIT = 30000;  // Cycle ceiling, about twice the expected run
  logic clk = 1'b0, sys_rst = 1'b1, thermalWarningIn = 1'b0, pumpFaultIn = 1'b0;
  logic coilXBreakIn = 1'b0, coilYBreakIn = 1'b0, watchdogTimeoutIn = 1'b0;
  logic [3:0] xOvercurrentIn = 4'h0, yOvercurrentIn = 4'h0;
  logic thermalShutdownIn = 1'b0;
  logic [6:0] translatorStepPosition = 7'h00;
  wire logic spiClk, spiCs_n, spiDataIn, spiDataOut, spiDataOutEn_n, rangeLowered;
  wire logic watchdogEnableBit;
  wire logic [4:0] peakAmpCode;
  wire logic [1:0] peakRange;
  int errTotal = 0, nCompared = 0, cycleCount = 0, lowerCount = 0;
  int lowerBase = 0;  // Pulse count before a write, so only one process drives lowerCount
  logic [7:0] rdData, staleData;
  logic [4:0] prevCode;
  logic [4:0] codes [10] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h1f, 5'h19, 5'h17, 5'h0f,
                             5'h10, 5'h00};
  logic [3:0] livePat [4] = '{4'hf, 4'h5, 4'ha, 4'h0};
  always #4 clk = ~clk;  // 125 MHz
  ssc_spi_master master (.clk(clk), .spiClk(spiClk), .spiCs_n(spiCs_n),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn_n(spiDataOutEn_n));
  ssc_status_regs dut (.clk(clk), .sys_rst(sys_rst), .spiClk(spiClk), .spiCs_n(spiCs_n),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn_n(spiDataOutEn_n),
    .thermalWarningIn(thermalWarningIn), .pumpFaultIn(pumpFaultIn),
    .coilXBreakIn(coilXBreakIn), .coilYBreakIn(coilYBreakIn),
    .watchdogTimeoutIn(watchdogTimeoutIn), .xOvercurrentIn(xOvercurrentIn),
    .yOvercurrentIn(yOvercurrentIn), .thermalShutdownIn(thermalShutdownIn),
    .translatorStepPosition(translatorStepPosition), .peakAmpCode(peakAmpCode),
    .peakRange(peakRange), .rangeLowered(rangeLowered),
    .watchdogEnableBit(watchdogEnableBit));
  // ****************************************************************
  // Helpers: comparison, parity word, bus cycles, verdict
  // ****************************************************************
  // Counts one-cycle pulses so a write can be judged after it ends
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (rangeLowered === 1'b1) lowerCount <= lowerCount + 1;
    if (cycleCount == LIMIT) begin
      errTotal = errTotal + 1;  // A hang counts as a mismatch
      close_out();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    nCompared = nCompared + 1;
    if (seen !== want) begin
      errTotal = errTotal + 1;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Even check bit on top of seven data bits
  function automatic logic [7:0] withPar(input logic [6:0] b);
    return {^b, b};
  endfunction
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    master.xfer({3'h0, a}, 8'h00, staleData, d);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] s0, s1;
    master.xfer({3'h4, a}, d, s0, s1);
  endtask
  // Holds an async event long enough for the synchronisers
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic close_out();
    if (errTotal == 0 && nCompared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    check({7'h0, spiDataOutEn_n}, 8'h01);            // Pin released after reset
    check({3'h0, peakAmpCode}, {3'h0, PEAK_CODE_RST});
    for (int a = 4; a < 8; a++) begin
      rd(a[4:0], rdData);
      check(rdData, STATUS_RST);
    end
    // Live flags follow their inputs, nothing latched
    foreach (livePat[i]) begin
      @(posedge clk);
      {thermalWarningIn, pumpFaultIn, coilXBreakIn, coilYBreakIn} <= livePat[i];
      settle();
      rd(ADDR_LIVE_DIAG, rdData);
      check(rdData, withPar({livePat[i][3:2], 1'b0, livePat[i][1:0], 2'b00}));
    end
    // Each overcurrent flag latches, survives its cause, clears once read
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      xOvercurrentIn    <= 4'h1 << i;
      yOvercurrentIn    <= 4'h8 >> i;
      thermalShutdownIn <= i[0];
      settle();
      xOvercurrentIn    <= 4'h0;
      yOvercurrentIn    <= 4'h0;
      thermalShutdownIn <= 1'b0;
      settle();
      rd(ADDR_X_BRIDGE, rdData);
      check(rdData, withPar({4'h1 << i, 3'h0}));
      rd(ADDR_Y_BRIDGE, rdData);
      check(rdData, withPar({4'h8 >> i, i[0], 2'h0}));
      rd(ADDR_X_BRIDGE, rdData);
      check(rdData, STATUS_RST);
      rd(ADDR_Y_BRIDGE, rdData);
      check(rdData, STATUS_RST);
    end
    // Step position, and the first byte of a frame carrying the old buffer
    @(posedge clk);
    translatorStepPosition <= 7'h55;
    rd(ADDR_STEP_POS, rdData);
    check(rdData, withPar(7'h55));
    @(posedge clk);
    translatorStepPosition <= 7'h7f;
    rd(ADDR_STEP_POS, rdData);
    check(staleData, withPar(7'h55));
    check(rdData, withPar(7'h7f));
    // Watchdog flag: set by the event, cleared only by writing enable zero
    @(posedge clk);
    watchdogTimeoutIn <= 1'b1;
    settle();
    watchdogTimeoutIn <= 1'b0;
    settle();
    rd(ADDR_LIVE_DIAG, rdData);
    check(rdData, withPar(7'h10));
    wr(ADDR_WDOG_CTRL, 8'h80);
    check({7'h0, watchdogEnableBit}, 8'h01);
    wr(ADDR_PEAK_CTRL, 8'h00);
    rd(ADDR_LIVE_DIAG, rdData);
    check(rdData, withPar(7'h10));
    wr(ADDR_WDOG_CTRL, 8'h00);
    rd(ADDR_LIVE_DIAG, rdData);
    check(rdData, STATUS_RST);
    // Peak codes across all range boundaries, up and down
    prevCode = 5'h00;  // Code of the last peak write above
    foreach (codes[i]) begin
      lowerBase = lowerCount;
      wr(ADDR_PEAK_CTRL, {3'h0, codes[i]});
      check({3'h0, peakAmpCode}, {3'h0, codes[i]});
      check({6'h0, peakRange}, {6'h0, codes[i][4:3]});
      check(8'(lowerCount - lowerBase), {7'h0, codes[i][4:3] < prevCode[4:3]});
      prevCode = codes[i];
    end
    // Refused accesses: unmapped read, write to a status address
    rd(5'h02, rdData);
    check(rdData, 8'h00);
    wr(ADDR_LIVE_DIAG, 8'hff);
    rd(ADDR_LIVE_DIAG, rdData);
    check(rdData, STATUS_RST);
    close_out();
  end
endmodule // tb_ssc_status_regs
